// file: rtl/rxaf_pkg.sv
package rxaf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame layout
    localparam int DA_BYTES = 6;
    localparam int POS_W = 9;
    localparam int FILT_NUM = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Wakeup filter store layout
    localparam int MASK_W = 31;
    localparam int CMD_W = 4;
    localparam int OFF_W = 8;
    localparam int CRC16_W = 16;
    localparam int CMD_EN_BIT = 0;
    localparam int CMD_TYPE_BIT = 3;
    localparam int CMD_LANE = 8;
    localparam int OFF_LANE = 8;
    localparam int CRC_LANE = 16;
    localparam logic [2:0] WPTR_RST = 3'h0;
    localparam logic [2:0] WORD_MASK3 = 3'h3;
    localparam logic [2:0] WORD_CMD = 3'h4;
    localparam logic [2:0] WORD_OFF = 3'h5;
    localparam logic [2:0] WORD_CRC_10 = 3'h6;
    localparam logic [2:0] WORD_CRC_32 = 3'h7;
    localparam logic [MASK_W-1:0] MASK_RST = 31'h0;
    localparam logic [CMD_W-1:0] CMD_RST = 4'h0;
    localparam logic [OFF_W-1:0] OFF_RST = 8'h0;
    localparam logic [CRC16_W-1:0] CRC16_RST = 16'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // CRC engines
    localparam logic [31:0] CRC32_INIT = 32'hffffffff;
    localparam logic [31:0] CRC32_POLY = 32'h04c11db7;
    localparam int HASH_IDX_LSB = 26;
    localparam logic [15:0] CRC16_INIT = 16'hffff;
    localparam logic [15:0] CRC16_POLY = 16'h8005;

    // Data bits enter least significant first, as on the wire
    function automatic logic [15:0] rxaf_crc16_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            r = (r[15] ^ d[b]) ? ({r[14:0], 1'h0} ^ CRC16_POLY) : {r[14:0], 1'h0};
        end
        return r;
    endfunction : rxaf_crc16_byte

endpackage : rxaf_pkg

// file: rtl/rxaf_byte_if.sv
`timescale 1ns/1ns
interface rxaf_byte_if
    import rxaf_pkg::*;
();
    logic valid;
    logic sof;
    logic [7:0] data;
    logic [POS_W-1:0] pos;

    modport src (output valid, output sof, output data, output pos);
    modport dst (input valid, input sof, input data, input pos);
endinterface : rxaf_byte_if

// file: rtl/rxaf_wake_filter.sv
`timescale 1ns/1ns
module rxaf_wake_filter
    import rxaf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Byte stream
    rxaf_byte_if.dst bus,
    // Filter setup
    input wire logic [MASK_W-1:0] cfg_mask,
    input wire logic [OFF_W-1:0] cfg_offset,
    input wire logic [CRC16_W-1:0] cfg_crc,
    // Result
    output logic crc_match
);

    logic [POS_W-1:0] rel;
    logic incl;
    logic [CRC16_W-1:0] crc;

    ////////////////////////////////////////////////////////////////////////////////
    // Byte window selection
    always_comb begin
        rel = POS_W'(bus.pos - POS_W'(cfg_offset));
        incl = bus.valid && (bus.pos >= POS_W'(cfg_offset)) && (rel < POS_W'(MASK_W))
            && cfg_mask[rel[4:0]];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Running CRC-16 over the selected bytes, restarted by each frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crc <= CRC16_INIT;
        end else if (bus.valid && bus.sof) begin
            crc <= incl ? rxaf_crc16_byte(CRC16_INIT, bus.data) : CRC16_INIT;
        end else if (incl) begin
            crc <= rxaf_crc16_byte(crc, bus.data);
        end
    end

    assign crc_match = (crc == cfg_crc);

    property p_no_byte_past_window;
        @(posedge clk) disable iff (rst)
        incl |-> (rel <= POS_W'(MASK_W - 1)) && (bus.pos >= POS_W'(cfg_offset));
    endproperty
    a_no_byte_past_window: assert property (p_no_byte_past_window) else $error("byte outside window");

endmodule : rxaf_wake_filter

// file: rtl/rxaf_addr_wake.sv
`timescale 1ns/1ns
//
// Overview of operation
// - All mode bits clear: accept only destinations equal to station address.
// - Hash-perfect only: physical perfect-matched, multicast hash-filtered.
// - Hash and hash-perfect set: physical and multicast both hash-filtered.
// - Inverse only: accept destinations differing from station address, reject equal.
// - Promiscuous without inverse: accept every frame including broadcasts.
// - Pass-all-multicast accepts multicast; physical perfect or hash per hash bits.
// - First destination bit marks multicast versus physical.
// - Frames failing the filter are not passed toward the host.
// - Station address is high register concatenated with low register.
// - Hash index is top six CRC bits into a 64-bit table.
// - Index MSB picks high or low word; five bits pick the bit.
// - Wake enable suspends normal reception; frames only checked against patterns.
// - Wakeup frame raises wake event and sets the received flag.
// - Clearing wake enable restores normal filtering and delivery.
// - Four independent filters; enabled filter plus address check plus CRC match.
// - Mask bit j includes frame byte offset plus j in the CRC.
// - Eight writes load masks, commands, offsets, CRCs 1:0, CRCs 3:2.
// - Wake detection runs in any power state whenever enabled.
// - Broadcast wake frame wakes despite broadcast disable.
// - Command bit 0 enables; bit 3 selects multicast or unicast patterns.
// - Offset is eight bits; zero is first destination address byte.
// - Stored 16-bit CRC compared with computed CRC; equal means wake.
// - Wake for broadcast, unicast with global enable, or regular pass with type.
module rxaf_addr_wake
    import rxaf_pkg::*;
(
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Receive byte stream
    input wire logic RX_VALID,
    input wire logic RX_SOF,
    input wire logic RX_EOF,
    input wire logic [7:0] RX_DATA,
    // Filter mode
    input wire logic PASS_ALL_MULTICAST,
    input wire logic PROMISCUOUS_SEL,
    input wire logic INVERSE_FILTER_SEL,
    input wire logic HASH_ONLY_SEL,
    input wire logic HASH_PERFECT_SEL,
    input wire logic BROADCAST_DISABLE,
    // Station address and hash table
    input wire logic [15:0] STATION_ADDR_HIGH,
    input wire logic [31:0] STATION_ADDR_LOW,
    input wire logic [31:0] HASH_TABLE_HIGH,
    input wire logic [31:0] HASH_TABLE_LOW,
    // Wake control
    input wire logic WAKE_DETECT_ENABLE,
    input wire logic WAKE_GLOBAL_UNICAST,
    input wire logic WAKE_FLAG_CLEAR,
    // Wakeup filter store write port
    input wire logic WAKEUP_FILTER_STORE_WR,
    input wire logic [31:0] WAKEUP_FILTER_STORE_DATA,
    // Filter verdict
    output logic FRAME_ACCEPT,
    output logic FRAME_DROP,
    output logic RX_PASS,
    // Wake results
    output logic WAKE_EVENT,
    output logic WAKE_FRAME_RECEIVED,
    output logic [FILT_NUM-1:0] WAKE_FILTER_HIT
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [POS_W-1:0] byte_cnt;
    logic [POS_W-1:0] cur_pos;
    logic [7:0] da_byte [DA_BYTES];
    logic [31:0] crc32;
    logic da_done;
    logic da_valid;
    logic eof_d;
    logic [47:0] station;
    logic perfect_hit;
    logic hash_hit;
    logic [5:0] hash_idx;
    logic is_mcast;
    logic is_broadcast_disable;
    logic addr_ok;
    logic accept_cond;
    logic drop_cond;
    logic [2:0] wptr;
    logic [MASK_W-1:0] wf_mask [FILT_NUM];
    logic [CMD_W-1:0] wf_cmd [FILT_NUM];
    logic [OFF_W-1:0] wf_off [FILT_NUM];
    logic [CRC16_W-1:0] wf_crc [FILT_NUM];
    logic [FILT_NUM-1:0] crc_match;
    logic [FILT_NUM-1:0] next_hit;
    logic wake_now;

    rxaf_byte_if byte_bus ();

    ////////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int b = 0; b < 8; b++) begin
            r = (r[31] ^ d[b]) ? ({r[30:0], 1'h0} ^ CRC32_POLY) : {r[30:0], 1'h0};
        end
        return r;
    endfunction : crc32_byte

    function automatic logic addr_pass(
        input logic pass_all_multicast,
        input logic promiscuous_sel,
        input logic inv,
        input logic hf,
        input logic hp,
        input logic bdis,
        input logic mc,
        input logic bc,
        input logic perf,
        input logic hsh
    );
        logic ok;
        ok = 1'h0;
        if (promiscuous_sel && !inv) begin
            ok = 1'h1;
        end else if (bc && bdis) begin
            ok = 1'h0;
        end else if (mc && pass_all_multicast) begin
            ok = 1'h1;
        end else if (inv) begin
            ok = !perf;
        end else if (mc) begin
            ok = hp ? hsh : perf;
        end else begin
            ok = (hf && hp) ? hsh : perf;
        end
        return ok;
    endfunction : addr_pass

    ////////////////////////////////////////////////////////////////////////////////
    // Byte position and stream to the wake filters
    assign cur_pos = RX_SOF ? '0 : byte_cnt;
    assign byte_bus.valid = RX_VALID;
    assign byte_bus.sof = RX_SOF;
    assign byte_bus.data = RX_DATA;
    assign byte_bus.pos = cur_pos;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            byte_cnt <= '0;
        end else if (RX_VALID && (cur_pos != '1)) begin
            byte_cnt <= POS_W'(cur_pos + POS_W'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Destination address capture and CRC-32 for hashing
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int k = 0; k < DA_BYTES; k++) begin
                da_byte[k] <= 8'h0;
            end
        end else if (RX_VALID && (cur_pos < POS_W'(DA_BYTES))) begin
            da_byte[cur_pos[2:0]] <= RX_DATA;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            crc32 <= CRC32_INIT;
        end else if (RX_VALID && RX_SOF) begin
            crc32 <= crc32_byte(CRC32_INIT, RX_DATA);
        end else if (RX_VALID && (cur_pos < POS_W'(DA_BYTES))) begin
            crc32 <= crc32_byte(crc32, RX_DATA);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            da_done <= 1'h0;
            eof_d <= 1'h0;
        end else begin
            da_done <= RX_VALID && (cur_pos == POS_W'(DA_BYTES - 1));
            eof_d <= RX_VALID && RX_EOF;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            da_valid <= 1'h0;
        end else if (RX_VALID && (cur_pos == POS_W'(DA_BYTES - 1))) begin
            da_valid <= 1'h1;
        end else if (RX_VALID && RX_SOF) begin
            da_valid <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Address classification and match
    always_comb begin
        station = {STATION_ADDR_HIGH, STATION_ADDR_LOW};
        perfect_hit = 1'h1;
        is_broadcast_disable = 1'h1;
        for (int k = 0; k < DA_BYTES; k++) begin
            perfect_hit = perfect_hit && (da_byte[k] == station[8*k +: 8]);
            is_broadcast_disable = is_broadcast_disable && (da_byte[k] == 8'hff);
        end
        is_mcast = da_byte[0][0];
        hash_idx = crc32[31:HASH_IDX_LSB];
        hash_hit = hash_idx[5] ? HASH_TABLE_HIGH[hash_idx[4:0]] : HASH_TABLE_LOW[hash_idx[4:0]];
        addr_ok = addr_pass(PASS_ALL_MULTICAST, PROMISCUOUS_SEL, INVERSE_FILTER_SEL,
            HASH_ONLY_SEL, HASH_PERFECT_SEL, BROADCAST_DISABLE, is_mcast, is_broadcast_disable,
            perfect_hit, hash_hit);
        accept_cond = da_done && !WAKE_DETECT_ENABLE && addr_ok;
        drop_cond = (da_done && (WAKE_DETECT_ENABLE || !addr_ok))
            || (RX_VALID && RX_EOF && (cur_pos < POS_W'(DA_BYTES - 1)));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame verdict
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            FRAME_ACCEPT <= 1'h0;
            FRAME_DROP <= 1'h0;
        end else begin
            FRAME_ACCEPT <= accept_cond;
            FRAME_DROP <= drop_cond;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RX_PASS <= 1'h0;
        end else if (accept_cond) begin
            RX_PASS <= 1'h1;
        end else if (drop_cond || (RX_VALID && RX_SOF)) begin
            RX_PASS <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wakeup filter store
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wptr <= WPTR_RST;
        end else if (WAKEUP_FILTER_STORE_WR) begin
            wptr <= 3'(wptr + 3'h1);
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < FILT_NUM; i++) begin
                wf_mask[i] <= MASK_RST;
                wf_cmd[i] <= CMD_RST;
                wf_off[i] <= OFF_RST;
                wf_crc[i] <= CRC16_RST;
            end
        end else if (WAKEUP_FILTER_STORE_WR) begin
            case (wptr)
                WORD_CMD: begin
                    for (int i = 0; i < FILT_NUM; i++) begin
                        wf_cmd[i] <= WAKEUP_FILTER_STORE_DATA[CMD_LANE*i +: CMD_W];
                    end
                end
                WORD_OFF: begin
                    for (int i = 0; i < FILT_NUM; i++) begin
                        wf_off[i] <= WAKEUP_FILTER_STORE_DATA[OFF_LANE*i +: OFF_W];
                    end
                end
                WORD_CRC_10: begin
                    wf_crc[0] <= WAKEUP_FILTER_STORE_DATA[0 +: CRC16_W];
                    wf_crc[1] <= WAKEUP_FILTER_STORE_DATA[CRC_LANE +: CRC16_W];
                end
                WORD_CRC_32: begin
                    wf_crc[2] <= WAKEUP_FILTER_STORE_DATA[0 +: CRC16_W];
                    wf_crc[3] <= WAKEUP_FILTER_STORE_DATA[CRC_LANE +: CRC16_W];
                end
                default: begin
                    wf_mask[wptr[1:0]] <= WAKEUP_FILTER_STORE_DATA[MASK_W-1:0];
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Four pattern filters
    generate
        for (genvar g = 0; g < FILT_NUM; g++) begin : g_filt
            rxaf_wake_filter u_filt (
                .clk(CORE_CLK),
                .rst(RST),
                .bus(byte_bus),
                .cfg_mask(wf_mask[g]),
                .cfg_offset(wf_off[g]),
                .cfg_crc(wf_crc[g]),
                .crc_match(crc_match[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Wake decision at end of frame
    always_comb begin
        for (int i = 0; i < FILT_NUM; i++) begin
            next_hit[i] = wf_cmd[i][CMD_EN_BIT] && crc_match[i] && da_valid
                && (is_broadcast_disable
                || (!is_mcast && WAKE_GLOBAL_UNICAST)
                || (addr_ok && is_mcast && !is_broadcast_disable && wf_cmd[i][CMD_TYPE_BIT])
                || (addr_ok && !is_mcast && !wf_cmd[i][CMD_TYPE_BIT]));
        end
        wake_now = eof_d && WAKE_DETECT_ENABLE && (|next_hit);
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            WAKE_EVENT <= 1'h0;
        end else begin
            WAKE_EVENT <= wake_now;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            WAKE_FILTER_HIT <= '0;
        end else if (wake_now) begin
            WAKE_FILTER_HIT <= next_hit;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            WAKE_FRAME_RECEIVED <= 1'h0;
        end else if (wake_now) begin
            WAKE_FRAME_RECEIVED <= 1'h1;
        end else if (WAKE_FLAG_CLEAR) begin
            WAKE_FRAME_RECEIVED <= 1'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_wake_blocks_rx;
        @(posedge CORE_CLK) disable iff (RST)
        (da_done && WAKE_DETECT_ENABLE) |=> (FRAME_DROP && !FRAME_ACCEPT && !RX_PASS);
    endproperty
    a_wake_blocks_rx: assert property (p_wake_blocks_rx) else $error("rx while waking");

    property p_promisc_all;
        @(posedge CORE_CLK) disable iff (RST)
        (da_done && !WAKE_DETECT_ENABLE && PROMISCUOUS_SEL && !INVERSE_FILTER_SEL)
            |=> FRAME_ACCEPT ##1 RX_PASS;
    endproperty
    a_promisc_all: assert property (p_promisc_all) else $error("promiscuous dropped");

    property p_perfect_only;
        @(posedge CORE_CLK) disable iff (RST)
        (da_done && !WAKE_DETECT_ENABLE && !PASS_ALL_MULTICAST && !PROMISCUOUS_SEL
            && !INVERSE_FILTER_SEL && !HASH_ONLY_SEL && !HASH_PERFECT_SEL && !is_broadcast_disable)
            |=> (FRAME_ACCEPT == $past(perfect_hit));
    endproperty
    a_perfect_only: assert property (p_perfect_only) else $error("perfect mode wrong");

    property p_inverse;
        @(posedge CORE_CLK) disable iff (RST)
        (da_done && !WAKE_DETECT_ENABLE && !PASS_ALL_MULTICAST && !PROMISCUOUS_SEL
            && INVERSE_FILTER_SEL && !HASH_ONLY_SEL && !HASH_PERFECT_SEL && !is_broadcast_disable)
            |=> (FRAME_ACCEPT != $past(perfect_hit)) && (FRAME_DROP == $past(perfect_hit));
    endproperty
    a_inverse: assert property (p_inverse) else $error("inverse mode wrong");

    property p_hash_mcast;
        @(posedge CORE_CLK) disable iff (RST)
        (da_done && !WAKE_DETECT_ENABLE && !PASS_ALL_MULTICAST && !PROMISCUOUS_SEL
            && !INVERSE_FILTER_SEL && HASH_PERFECT_SEL && is_mcast && !is_broadcast_disable)
            |=> (FRAME_ACCEPT == $past(hash_hit));
    endproperty
    a_hash_mcast: assert property (p_hash_mcast) else $error("hash filter wrong");

    property p_drop_stops_pass;
        @(posedge CORE_CLK) disable iff (RST)
        FRAME_DROP |-> !RX_PASS ##1 !FRAME_ACCEPT;
    endproperty
    a_drop_stops_pass: assert property (p_drop_stops_pass) else $error("failed frame passed");

    property p_wake_flag;
        @(posedge CORE_CLK) disable iff (RST)
        WAKE_EVENT |-> WAKE_FRAME_RECEIVED && $past(eof_d) && $past(WAKE_DETECT_ENABLE);
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake without flag");

    property p_wptr_wrap;
        @(posedge CORE_CLK) disable iff (RST)
        (WAKEUP_FILTER_STORE_WR && (wptr == WORD_CRC_32)) |=> (wptr == WPTR_RST);
    endproperty
    a_wptr_wrap: assert property (p_wptr_wrap) else $error("store pointer no wrap");

    property p_mask_word;
        @(posedge CORE_CLK) disable iff (RST)
        (WAKEUP_FILTER_STORE_WR && (wptr <= WORD_MASK3))
            |=> (wf_mask[$past(wptr[1:0])] == $past(WAKEUP_FILTER_STORE_DATA[MASK_W-1:0]));
    endproperty
    a_mask_word: assert property (p_mask_word) else $error("mask word lost");

endmodule : rxaf_addr_wake

// file: test/rxaf_rx_src.sv
`timescale 1ns/1ns
module rxaf_rx_src (
    // Clock
    input wire logic clk,
    // Byte stream toward the filter
    output logic valid,
    output logic sof,
    output logic eof,
    output logic [7:0] data
);
    logic busy = 1'b0;

    initial begin
        valid = 1'b0;
        sof = 1'b0;
        eof = 1'b0;
        data = 8'h5a;
    end

    // Idle data keeps changing so a stale byte never looks valid
    always @(posedge clk) begin
        if (!busy)
            data <= ~data;
    end

    // Whole frame, SOF on first byte, EOF on last, no gaps
    task automatic send(input logic [47:0] da, input int n);
        busy = 1'b1;
        for (int k = 0; k < n; k++) begin
            valid <= 1'b1;
            sof <= (k == 0);
            eof <= (k == n - 1);
            data <= (k < 6) ? da[8*k +: 8] : (8'(k) ^ 8'hc0);
            @(posedge clk);
        end
        valid <= 1'b0;
        sof <= 1'b0;
        eof <= 1'b0;
        busy = 1'b0;
    endtask : send
endmodule : rxaf_rx_src

// file: test/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import rxaf_pkg::*;
();
    localparam logic [47:0] STA = 48'h3412_7856_9a02;
    localparam logic [47:0] OTH = 48'h3412_7856_9a04;
    localparam logic [47:0] MCO = 48'h0000_0000_0001;
    localparam logic [47:0] BC = 48'hffff_ffff_ffff;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic RX_VALID, RX_SOF, RX_EOF;
    logic [7:0] RX_DATA;
    logic [4:0] md = 5'h0;
    logic bdis = 1'b0, wen = 1'b0, wclr = 1'b0, swr = 1'b0, wgu = 1'b0;
    logic [31:0] sdat = 32'h0;
    logic [63:0] htab = 64'h0;
    logic FRAME_ACCEPT, FRAME_DROP, RX_PASS, WAKE_EVENT, WAKE_FRAME_RECEIVED;
    logic [FILT_NUM-1:0] WAKE_FILTER_HIT;
    logic clr = 1'b0;
    logic [2:0] seen = 3'h0;
    logic [31:0] wv [8];
    int errors = 0;
    int checks = 0;

    always #5 CORE_CLK = ~CORE_CLK;

    rxaf_rx_src src (.clk(CORE_CLK), .valid(RX_VALID), .sof(RX_SOF), .eof(RX_EOF),
        .data(RX_DATA));

    rxaf_addr_wake uut (.CORE_CLK(CORE_CLK), .RST(RST), .RX_VALID(RX_VALID),
        .RX_SOF(RX_SOF), .RX_EOF(RX_EOF), .RX_DATA(RX_DATA),
        .PASS_ALL_MULTICAST(md[4]), .PROMISCUOUS_SEL(md[3]), .INVERSE_FILTER_SEL(md[2]),
        .HASH_ONLY_SEL(md[1]), .HASH_PERFECT_SEL(md[0]), .BROADCAST_DISABLE(bdis),
        .STATION_ADDR_HIGH(STA[47:32]), .STATION_ADDR_LOW(STA[31:0]),
        .HASH_TABLE_HIGH(htab[63:32]), .HASH_TABLE_LOW(htab[31:0]),
        .WAKE_DETECT_ENABLE(wen), .WAKE_GLOBAL_UNICAST(wgu), .WAKE_FLAG_CLEAR(wclr),
        .WAKEUP_FILTER_STORE_WR(swr), .WAKEUP_FILTER_STORE_DATA(sdat),
        .FRAME_ACCEPT(FRAME_ACCEPT), .FRAME_DROP(FRAME_DROP), .RX_PASS(RX_PASS),
        .WAKE_EVENT(WAKE_EVENT), .WAKE_FRAME_RECEIVED(WAKE_FRAME_RECEIVED),
        .WAKE_FILTER_HIT(WAKE_FILTER_HIT));

    // Collects the one-cycle verdict pulses of the current frame
    always @(posedge CORE_CLK) begin
        if (clr)
            seen <= 3'h0;
        else
            seen <= seen | {FRAME_ACCEPT === 1'b1, FRAME_DROP === 1'b1, WAKE_EVENT === 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reference CRC, bits taken least significant first
    function automatic logic [31:0] crc(input logic [47:0] d, input logic [31:0] c,
        input logic [31:0] p, input int w);
        logic t;
        for (int i = 0; i < 48; i++) begin
            t = c[w-1] ^ d[i];
            c = c << 1;
            if (t)
                c = c ^ p;
        end
        return c & (32'hffffffff >> (32 - w));
    endfunction : crc

    function automatic logic [63:0] hbit(input logic [47:0] da);
        logic [31:0] c;
        c = crc(da, CRC32_INIT, CRC32_POLY, 32);
        return 64'h1 << c[31:26];
    endfunction : hbit

    // Pattern CRC-16 over the six destination bytes
    function automatic logic [15:0] c16(input logic [47:0] da);
        return 16'(crc(da, {16'h0, CRC16_INIT}, {16'h0, CRC16_POLY}, 16));
    endfunction : c16

    task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Expected bits: accept, drop, wake
    task automatic fr(input logic [47:0] da, input logic [2:0] e);
        clr <= 1'b1;
        @(posedge CORE_CLK);
        clr <= 1'b0;
        src.send(da, 8);
        repeat (4) @(posedge CORE_CLK);
        chk("verdict", {1'b0, e}, {1'b0, seen});
    endtask : fr

    task automatic end_sim();
        if (errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        wv = '{32'h3f, 32'h3f, 32'h3f, 32'h0, 32'h10101, 32'h0, 32'h0, 32'h0};
        wv[6] = {c16(BC), c16(STA)};
        wv[7] = {16'h0, c16(OTH)};
        repeat (5) @(posedge CORE_CLK);
        RST <= 1'b0;
        @(posedge CORE_CLK);
        fr(STA, 3'b100);
        fr(OTH, 3'b010);
        fr(MCO, 3'b010);
        md <= 5'b00100;
        fr(STA, 3'b010);
        fr(OTH, 3'b100);
        md <= 5'b01011;
        bdis <= 1'b1;
        fr(BC, 3'b100);
        bdis <= 1'b0;
        md <= 5'b10000;
        fr(MCO, 3'b100);
        fr(OTH, 3'b010);
        md <= 5'b00011;
        htab <= hbit(OTH);
        fr(OTH, 3'b100);
        md <= 5'b10011;
        fr(OTH, 3'b100);
        md <= 5'b00011;
        htab <= ~hbit(OTH);
        fr(OTH, 3'b010);
        md <= 5'b00001;
        htab <= hbit(MCO);
        fr(MCO, 3'b100);
        fr(OTH, 3'b010);
        md <= 5'b00000;
        for (int i = 0; i < 16; i++) begin
            swr <= 1'b1;
            sdat <= (i < 8) ? 32'hffffffff : wv[i % 8];
            @(posedge CORE_CLK);
        end
        swr <= 1'b0;
        wen <= 1'b1;
        fr(STA, 3'b011);
        chk("hit", 4'h1, WAKE_FILTER_HIT);
        chk("flag", 4'h1, {3'h0, WAKE_FRAME_RECEIVED});
        wclr <= 1'b1;
        @(posedge CORE_CLK);
        wclr <= 1'b0;
        @(posedge CORE_CLK);
        chk("flag", 4'h0, {3'h0, WAKE_FRAME_RECEIVED});
        bdis <= 1'b1;
        fr(BC, 3'b011);
        chk("hit", 4'h2, WAKE_FILTER_HIT);
        fr(OTH, 3'b010);
        wgu <= 1'b1;
        fr(OTH, 3'b011);
        chk("hit", 4'h4, WAKE_FILTER_HIT);
        wen <= 1'b0;
        bdis <= 1'b0;
        fr(STA, 3'b100);
        chk("pass", 4'h1, {3'h0, RX_PASS});
        end_sim();
    end
endmodule : tb_top
